// ===== design/dfr_flag_regs.sv
`timescale 1ns/1ps
`include "dfr_map.svh"
// Notes on behaviour
// (RULE1) Oscillator watchdog trip sets error bit 4
// (RULE2) Supply pin low sets error bit 3
// (RULE3) Analog rail low sets error bit 2
// (RULE4) Field below low limit sets bit 1
// (RULE5) Reset sets error bit 0, self-test does not
// (RULE6) Warnings latch until read and cleared
// (RULE7) Fixed IDs 1011 and 1111; words read-only
// (RULE8) Bad length or bit15 discards, sets bit 11
// (RULE9) Optional checksum check, bad sets bit 10
// (RULE10) Active slew limiting sets warning bit 8
// (RULE11) Failed extended command sets bit 7
// (RULE12) Temperature out of range sets 6, clamps
// (RULE13) Corrected memory error on load sets 5
// (RULE14) Any saturation sets warning bit 4
// (RULE15) Zero-cross step over 135 degrees sets 3
// (RULE16) Overlapping extended access sets bit 2
// (RULE17) Field above high limit sets bit 1
// (RULE18) Turns past limits sets warning bit 0
// (RULE19) Only turns reset clears turns overflow
// (RULE20) Temperature 12-bit eighths relative to 25
// (RULE21) Error flags latch until read and cleared
// (RULE22) Warning summary in error bit 11, maskable
// (RULE23) Fault indicator on any unmasked flag
// (RULE24) Low supply is OR of both, masked
// (RULE25) Host clear; present condition re-sets flag
module dfr_flag_regs (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic [9:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Fault sources
   input wire logic osc_fast_trip_i,
   input wire logic osc_slow_trip_i,
   input wire logic supply_pin_low_i,
   input wire logic analog_rail_low_i,
   input wire logic [11:0] field_gauss_i,
   input wire logic field_valid_i,
   // Serial packet checks
   input wire logic pkt_done_i,
   input wire logic [5:0] pkt_bits_i,
   input wire logic pkt_bit15_i,
   input wire logic pkt_crc_ok_i,
   input wire logic line_code_err_i,
   // Other warning sources
   input wire logic slew_limiting_i,
   input wire logic ext_unlock_err_i,
   input wire logic ext_nvm_fail_i,
   input wire logic signed [15:0] temp_raw_i,
   input wire logic temp_valid_i,
   input wire logic nvm_load_i,
   input wire logic nvm_single_err_i,
   input wire logic [3:0] sat_detect_i,
   input wire logic zcd_valid_i,
   input wire logic [11:0] zcd_angle_i,
   input wire logic ext_start_i,
   input wire logic ext_busy_i,
   input wire logic turns_up_i,
   input wire logic turns_down_i,
   input wire logic [11:0] turns_count_i,
   // Status outputs
   output logic pkt_accept_o,
   output logic pkt_discard_o,
   output logic turns_reset_o,
   output logic any_fault_flag_o,
   output logic low_supply_flag_o,
   output logic caution_summary_o
);
   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
      hit = (a[9:2] == idx);
   endfunction

   dfr_pkg::dfr_bus_t bus_st;
   // No request is taken in the ack cycle
   wire req = cyc_i & stb_i & (bus_st == dfr_pkg::DFR_BUS_IDLE);
   wire wr = req & we_i;
   // Writes land only at the edge that takes the request
   wire wr_ctrl = wr & hit(adr_i, `DFR_IDX_CTRL) & sel_i[0];
   wire wr_cfg = wr & hit(adr_i, `DFR_IDX_CFG);
   wire wr_limit = wr & hit(adr_i, `DFR_IDX_LIMIT);
   wire wr_wmask = wr & hit(adr_i, `DFR_IDX_WMASK);

   logic [31:0] cfg;
   dfr_pkg::dfr_word12_t low_lim;
   dfr_pkg::dfr_word12_t high_lim;
   dfr_pkg::dfr_word12_t wmask;
   logic [11:0] warn;
   dfr_pkg::dfr_err_t err;
   logic [11:0] temp_word;
   logic [11:0] zcd_prev;
   logic zcd_seen;

   wire clr_err = wr_ctrl & dat_i[`DFR_CTRL_CLR_ERR];
   wire clr_warn = wr_ctrl & dat_i[`DFR_CTRL_CLR_WARN];
   wire turns_rst = wr_ctrl & dat_i[`DFR_CTRL_TURNS_RST];
   wire crc_en = cfg[`DFR_CFG_CRC_EN];
   wire eighth = cfg[`DFR_CFG_EIGHTH];
   wire [4:0] emask = cfg[`DFR_CFG_EMASK_HI:`DFR_CFG_EMASK_LO];

   // ----------------------------------------
   // Temperature clamp
   // ----------------------------------------
   dfr_temp_if tif ();
   assign tif.raw = temp_raw_i;
   dfr_temp_clamp u_clamp (
      .t(tif.conv)
   );

   // ----------------------------------------
   // Event detection
   // ----------------------------------------
   // Plain packets and packets carrying a checksum nibble
   wire len_ok = (pkt_bits_i == `DFR_PKT_BITS) | (pkt_bits_i == `DFR_PKT_BITS_CRC);
   // (RULE8) wrong length or bit 15
   wire pkt_bad_fmt = pkt_done_i & (~len_ok | pkt_bit15_i);
   // (RULE9) checksum only when enabled
   wire pkt_bad_crc = pkt_done_i & ~pkt_bad_fmt & crc_en & ~pkt_crc_ok_i;

   // Modular difference, so wrapping through zero is a short step
   wire [12:0] zdiff_raw = {1'b0, zcd_angle_i} - {1'b0, zcd_prev};
   wire [11:0] zdiff = zdiff_raw[11:0];
   wire [12:0] zdiff_neg = `DFR_ANG_FULL - {1'b0, zdiff};
   wire [11:0] zstep = zdiff[11] ? zdiff_neg[11:0] : zdiff;
   // (RULE15) shortest step over 135 degrees
   wire tstep_ev = zcd_valid_i & zcd_seen & (zstep > `DFR_STEP_LIM);

   wire [11:0] tmax = eighth ? `DFR_TURNS_MAX_EIGHTH : `DFR_TURNS_MAX_HALF;
   wire [11:0] tmin = eighth ? `DFR_TURNS_MIN_EIGHTH : `DFR_TURNS_MIN_HALF;
   // (RULE18) step beyond count limit
   wire tov_ev = (turns_up_i & (turns_count_i == tmax)) |
                 (turns_down_i & (turns_count_i == tmin));

   logic [11:0] wset;
   always_comb begin
      wset = 12'h000;
      wset[`DFR_W_IFACE] = pkt_bad_fmt | line_code_err_i;
      wset[`DFR_W_CRC] = pkt_bad_crc;
      // (RULE10) enabled and limiting
      wset[`DFR_W_SLEW] = cfg[`DFR_CFG_SLEW_EN] & slew_limiting_i;
      // (RULE11) failed extended command
      wset[`DFR_W_XCMD] = ext_unlock_err_i | ext_nvm_fail_i;
      // (RULE12) temperature range flag
      wset[`DFR_W_TEMP] = temp_valid_i & tif.out_of_range;
      // (RULE13) checked at load only
      wset[`DFR_W_ECC] = nvm_load_i & nvm_single_err_i;
      // (RULE14) aggregate saturation
      wset[`DFR_W_SAT] = |sat_detect_i;
      wset[`DFR_W_TSTEP] = tstep_ev;
      // (RULE16) start while busy
      wset[`DFR_W_BUSY] = ext_start_i & ext_busy_i;
      // (RULE17) field above high limit
      wset[`DFR_W_FHIGH] = field_valid_i & (field_gauss_i > high_lim);
      wset[`DFR_W_TOV] = tov_ev;
   end

   wire [4:0] eset = {
      // (RULE1) either watchdog trips
      osc_fast_trip_i | osc_slow_trip_i,
      // (RULE2) set while supply low
      supply_pin_low_i,
      // (RULE3) set while rail low
      analog_rail_low_i,
      // (RULE4) field below low limit
      field_valid_i & (field_gauss_i < low_lim),
      1'b0
   };

   // ----------------------------------------
   // Latched warning flags
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 12; gi++) begin : g_warn
         // (RULE19) overflow cleared only by turns reset
         wire clr_bit = (gi == `DFR_W_TOV) ? turns_rst : clr_warn;
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               warn[gi] <= 1'b0;
            end else begin
               // (RULE6) latch, set wins over clear
               warn[gi] <= (warn[gi] & ~clr_bit) | wset[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Latched error flags
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // (RULE5) reset marks volatile state lost
         err <= `DFR_RST_ERR;
      end else begin
         // (RULE21) latch until cleared
         // (RULE25) present condition re-sets
         err <= (err & ~{5{clr_err}}) | eset;
      end
   end

   // ----------------------------------------
   // Summaries
   // ----------------------------------------
   // Registered below, so caution and fault summaries trail the flags by one cycle
   wire [11:0] warn_live = warn & ~wmask;
   wire [4:0] err_live = err & ~emask;
   // (RULE22) summary unless masked
   wire next_summary = (|warn_live) & ~cfg[`DFR_CFG_SUM_MASK];
   // (RULE23) any unmasked flag
   wire next_fault = (|warn_live) | (|err_live);
   // (RULE24) real-time OR, masked
   wire next_low = (supply_pin_low_i & ~emask[`DFR_E_UVD]) |
                   (analog_rail_low_i & ~emask[`DFR_E_UVA]);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         caution_summary_o <= 1'b0;
         any_fault_flag_o <= 1'b0;
         low_supply_flag_o <= 1'b0;
         pkt_accept_o <= 1'b0;
         pkt_discard_o <= 1'b0;
         turns_reset_o <= 1'b0;
      end else begin
         caution_summary_o <= next_summary;
         any_fault_flag_o <= next_fault;
         low_supply_flag_o <= next_low;
         pkt_accept_o <= pkt_done_i & ~pkt_bad_fmt & ~pkt_bad_crc;
         pkt_discard_o <= pkt_bad_fmt | pkt_bad_crc;
         turns_reset_o <= turns_rst;
      end
   end

   // ----------------------------------------
   // Sample history and temperature word
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         zcd_prev <= 12'h000;
         zcd_seen <= 1'b0;
         temp_word <= 12'h000;
      end else begin
         if (zcd_valid_i) begin
            zcd_prev <= zcd_angle_i;
            zcd_seen <= 1'b1;
         end
         // (RULE20) updated on each conversion
         if (temp_valid_i) begin
            temp_word <= tif.clamped;
         end
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            merge[b*8 +: 8] = d[b*8 +: 8];
         end
      end
   endfunction

   // Byte enables merge into the packed register image
   wire [31:0] lim_word = {4'h0, high_lim, 4'h0, low_lim};
   wire [31:0] lim_next = merge(lim_word, dat_i, sel_i);
   wire [31:0] wm_next = merge({20'h0_0000, wmask}, dat_i, sel_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg <= `DFR_RST_CFG;
         low_lim <= `DFR_RST_LOW_LIM;
         high_lim <= `DFR_RST_HIGH_LIM;
         wmask <= `DFR_RST_WMASK;
      end else begin
         if (wr_cfg) begin
            cfg <= merge(cfg, dat_i, sel_i);
         end
         if (wr_limit) begin
            low_lim <= lim_next[11:0];
            high_lim <= lim_next[27:16];
         end
         if (wr_wmask) begin
            wmask <= wm_next[11:0];
         end
      end
   end

   // ----------------------------------------
   // Read path and acknowledge
   // ----------------------------------------
   // Bit 9 of the warning word has no source and reads zero
   wire [15:0] err_word = {`DFR_ID_ERR, caution_summary_o, 6'h00, err};
   // (RULE7) fixed identifiers, read-only
   wire [15:0] warn_word = {`DFR_ID_WARN, warn[11:10], 1'b0, warn[8:0]};
   wire [15:0] temp_rd = {`DFR_ID_TEMP, temp_word};

   wire [31:0] rd_mux =
      hit(adr_i, `DFR_IDX_ERR) ? {16'h0000, err_word} :
      hit(adr_i, `DFR_IDX_WARN) ? {16'h0000, warn_word} :
      hit(adr_i, `DFR_IDX_TEMP) ? {16'h0000, temp_rd} :
      hit(adr_i, `DFR_IDX_CFG) ? cfg :
      hit(adr_i, `DFR_IDX_LIMIT) ? lim_word :
      hit(adr_i, `DFR_IDX_WMASK) ? {20'h0_0000, wmask} :
      32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_st <= dfr_pkg::DFR_BUS_IDLE;
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         unique case (bus_st)
            dfr_pkg::DFR_BUS_IDLE: begin
               ack_o <= req;
               if (req) begin
                  dat_o <= we_i ? 32'h0000_0000 : rd_mux;
                  bus_st <= dfr_pkg::DFR_BUS_ACK;
               end
            end
            dfr_pkg::DFR_BUS_ACK: begin
               ack_o <= 1'b0;
               bus_st <= dfr_pkg::DFR_BUS_IDLE;
            end
         endcase
      end
   end
endmodule

// ===== design/dfr_map.svh
`ifndef DFR_MAP_SVH
`define DFR_MAP_SVH

// Register indexes, byte address is four times the index
`define DFR_IDX_ERR 8'h24
`define DFR_IDX_WARN 8'h26
`define DFR_IDX_TEMP 8'h28
`define DFR_IDX_CTRL 8'h40
`define DFR_IDX_CFG 8'h41
`define DFR_IDX_LIMIT 8'h42
`define DFR_IDX_WMASK 8'h43

// Hard-coded identifiers in bits 15:12
`define DFR_ID_ERR 4'hA
`define DFR_ID_WARN 4'hB
`define DFR_ID_TEMP 4'hF

// Control register bit positions (write-one pulses)
`define DFR_CTRL_CLR_ERR 0
`define DFR_CTRL_CLR_WARN 1
`define DFR_CTRL_TURNS_RST 2

// Configuration register bit positions
`define DFR_CFG_CRC_EN 0
`define DFR_CFG_SLEW_EN 1
`define DFR_CFG_SUM_MASK 2
`define DFR_CFG_EIGHTH 3
`define DFR_CFG_EMASK_LO 16
`define DFR_CFG_EMASK_HI 20

// Warning bit positions
`define DFR_W_IFACE 11
`define DFR_W_CRC 10
`define DFR_W_SLEW 8
`define DFR_W_XCMD 7
`define DFR_W_TEMP 6
`define DFR_W_ECC 5
`define DFR_W_SAT 4
`define DFR_W_TSTEP 3
`define DFR_W_BUSY 2
`define DFR_W_FHIGH 1
`define DFR_W_TOV 0

// Error bit positions
`define DFR_E_SUM 11
`define DFR_E_OSC 4
`define DFR_E_UVD 3
`define DFR_E_UVA 2
`define DFR_E_FLOW 1
`define DFR_E_RST 0

// Reset values
`define DFR_RST_CFG 32'h0000_0000
`define DFR_RST_LOW_LIM 12'h0C8
`define DFR_RST_HIGH_LIM 12'h4B0
`define DFR_RST_WMASK 12'h000
`define DFR_RST_ERR 5'h01

// Packet lengths accepted: plain and with checksum nibble
`define DFR_PKT_BITS 6'h10
`define DFR_PKT_BITS_CRC 6'h14

// 135 degrees in 12-bit angle units
`define DFR_STEP_LIM 12'h600
`define DFR_ANG_FULL 13'h1000

// Temperature clamp in eighths relative to 25 C: -60 C and 180 C
`define DFR_TEMP_MIN 16'hFD58
`define DFR_TEMP_MAX 16'h04D8

// Turns limits
`define DFR_TURNS_MAX_HALF 12'h1FF
`define DFR_TURNS_MIN_HALF 12'hE00
`define DFR_TURNS_MAX_EIGHTH 12'h7FF
`define DFR_TURNS_MIN_EIGHTH 12'h800

`endif

// ===== design/dfr_pkg.sv
package dfr_pkg;
   typedef logic [11:0] dfr_word12_t;
   typedef logic [4:0] dfr_err_t;
   typedef enum logic [1:0] {
      DFR_BUS_IDLE,
      DFR_BUS_ACK
   } dfr_bus_t;
endpackage

// ===== design/dfr_temp_clamp.sv
`timescale 1ns/1ps
`include "dfr_map.svh"
module dfr_temp_clamp (
   dfr_temp_if.conv t
);
   wire signed [15:0] lo = `DFR_TEMP_MIN;
   wire signed [15:0] hi = `DFR_TEMP_MAX;
   wire below = t.raw < lo;
   wire above = t.raw > hi;
   wire signed [15:0] signal_clipping_flag = below ? lo : (above ? hi : t.raw);

   // (RULE12) clamp at limits
   assign t.out_of_range = below | above;
   // (RULE20) eighths, twos complement
   assign t.clamped = signal_clipping_flag[11:0];
endmodule

// ===== design/dfr_temp_if.sv
`timescale 1ns/1ps
interface dfr_temp_if;
   logic signed [15:0] raw;
   logic [11:0] clamped;
   logic out_of_range;
   modport conv (input raw, output clamped, output out_of_range);
   modport user (output raw, input clamped, input out_of_range);
endinterface

// ===== tb/dfr_flag_regs_props.sv
`timescale 1ns/1ps
// ------------------------------------------
// Port-level checks of the flag register bank
// ------------------------------------------
module dfr_flag_regs_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic pkt_done_i,
   input wire logic [5:0] pkt_bits_i,
   input wire logic pkt_bit15_i,
   input wire logic pkt_accept_o,
   input wire logic pkt_discard_o,
   input wire logic turns_reset_o,
   input wire logic supply_pin_low_i,
   input wire logic analog_rail_low_i,
   input wire logic low_supply_flag_o,
   input wire logic any_fault_flag_o,
   input wire logic caution_summary_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_taken;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_bad_pkt;
      pkt_done_i && (pkt_bit15_i || (pkt_bits_i != 6'h10 && pkt_bits_i != 6'h14));
   endsequence
   chk_ack_one_cycle: assert property (s_taken |=> ack_o ##1 !ack_o)
      else $error("ack not a single cycle after request");
   chk_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   chk_bad_pkt_drop: assert property (s_bad_pkt |=> pkt_discard_o && !pkt_accept_o)
      else $error("bad packet not discarded");
   chk_accept_cause: assert property (pkt_accept_o |-> $past(pkt_done_i) && !$past(pkt_bit15_i))
      else $error("packet accepted without good packet");
   chk_discard_cause: assert property (pkt_discard_o |-> $past(pkt_done_i))
      else $error("discard without packet");
   chk_turns_pulse: assert property (turns_reset_o |-> ack_o ##1 !turns_reset_o)
      else $error("turns reset pulse not tied to write");
   chk_uv_clear: assert property (!supply_pin_low_i && !analog_rail_low_i |=> !low_supply_flag_o)
      else $error("low supply flag without cause");
   chk_summary_fault: assert property (caution_summary_o |-> any_fault_flag_o)
      else $error("summary set without fault indicator");
   chk_supply_fault: assert property (supply_pin_low_i |-> ##[1:3] any_fault_flag_o)
      else $error("fault indicator missing on low supply");
endmodule

bind dfr_flag_regs dfr_flag_regs_props i_props (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
   .pkt_done_i, .pkt_bits_i, .pkt_bit15_i, .pkt_accept_o, .pkt_discard_o, .turns_reset_o,
   .supply_pin_low_i, .analog_rail_low_i, .low_supply_flag_o, .any_fault_flag_o,
   .caution_summary_o);

// ===== tb/dfr_flag_regs_test.sv
`timescale 1ns/1ps
module dfr_flag_regs_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [9:0] adr_i, a;
   logic [31:0] dat_i, dat_o, rd;
   logic [3:0] sel_i, sat_detect_i;
   logic we_i, cyc_i, stb_i, ack_o, ok;
   logic osc_fast_trip_i, osc_slow_trip_i, supply_pin_low_i, analog_rail_low_i;
   logic [11:0] field_gauss_i, zcd_angle_i, turns_count_i;
   logic field_valid_i, pkt_done_i, pkt_bit15_i, pkt_crc_ok_i, line_code_err_i;
   logic [5:0] pkt_bits_i;
   logic slew_limiting_i, ext_unlock_err_i, ext_nvm_fail_i, temp_valid_i;
   logic signed [15:0] temp_raw_i;
   logic signed [15:0] traw = 16'sh04d9;
   logic nvm_load_i, nvm_single_err_i, zcd_valid_i, ext_start_i, ext_busy_i;
   logic turns_up_i, turns_down_i, pkt_accept_o, pkt_discard_o, turns_reset_o;
   logic any_fault_flag_o, low_supply_flag_o, caution_summary_o;
   logic [31:0] seed = 32'hae09_b883;
   int n_fail = 0;
   int compares = 0;
   // ------------------------------------------
   // Expected word after each source event
   // ------------------------------------------
   localparam logic [15:0] EXP [21] = '{16'ha010, 16'ha010, 16'ha008, 16'ha004, 16'ha002,
      16'hb800, 16'hb800, 16'hb800, 16'hb100, 16'hb400, 16'hb080, 16'hb080, 16'hb040,
      16'hb020, 16'hb010, 16'hb008, 16'hb004, 16'hb002, 16'hb001, 16'hb001, 16'hb000};
   localparam logic signed [15:0] TV [4] = '{16'sh7000, 16'sh8000, 16'sh04d8, -16'sh02a8};

   dfr_flag_regs i_dut (.*);
   dfr_host i_host (.clk_i, .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc_i), .stb_o(stb_i),
      .we_o(we_i), .adr_o(adr_i), .dat_o(dat_i), .sel_o(sel_i));

   always #12.5 clk_i = ~clk_i;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [31:0] exp_temp(input logic signed [15:0] r);
      if (r > 16'sh04d8) return 32'h0000_f4d8;
      if (r < -16'sh02a8) return 32'h0000_fd58;
      return {16'h0000, 4'hf, r[11:0]};
   endfunction
   task automatic complete_run();
      if (n_fail == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rw(input logic w, input logic [9:0] ad, input logic [31:0] d);
      i_host.xfer(w, ad, d, rd, ok);
      if (!ok) begin
         n_fail++;
         $display("unexpected bus ack expected 1 seen 0");
         complete_run();
      end
   endtask
   // Source index -1 leaves every condition benign
   task automatic drive(input int i);
      osc_fast_trip_i <= (i == 0);
      osc_slow_trip_i <= (i == 1);
      supply_pin_low_i <= (i == 2);
      analog_rail_low_i <= (i == 3);
      field_valid_i <= 1'b1;
      field_gauss_i <= (i == 4) ? 12'(seed % 200) : (i == 17) ? 12'(1201 + seed % 2800) : 12'h258;
      pkt_done_i <= (i inside {5, 6, 9, 20});
      pkt_bits_i <= (i == 5) ? 6'h11 : 6'h14;
      pkt_bit15_i <= (i == 6);
      pkt_crc_ok_i <= (i != 9);
      line_code_err_i <= (i == 7);
      slew_limiting_i <= (i == 8);
      ext_unlock_err_i <= (i == 10);
      ext_nvm_fail_i <= (i == 11);
      temp_raw_i <= (i == 12) ? traw : 16'sh0000;
      temp_valid_i <= (i == 12);
      nvm_load_i <= (i == 13);
      nvm_single_err_i <= (i == 13 || i == 20);
      sat_detect_i <= (i == 14) ? (seed[3:0] | 4'h1) : 4'h0;
      zcd_valid_i <= (i == 15 || i == 21);
      zcd_angle_i <= (i == 15) ? 12'h801 : 12'h000;
      ext_start_i <= (i == 16 || i == 20);
      ext_busy_i <= (i == 16);
      turns_up_i <= (i == 18);
      turns_down_i <= (i == 19);
      turns_count_i <= (i == 18) ? 12'h1ff : (i == 19) ? 12'he00 : 12'h000;
   endtask
   task automatic fire(input int i);
      @(posedge clk_i);
      seed = xs(seed);
      drive(i);
      @(posedge clk_i);
      drive(-1);
   endtask

   initial begin
      drive(-1);
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rw(0, 10'h090, 0);
      check("error word", rd, 32'h0000_a001);
      rw(0, 10'h098, 0);
      check("warning word", rd, 32'h0000_b000);
      rw(1, 10'h104, 32'h0000_0003);
      fire(21);
      @(posedge clk_i);
      supply_pin_low_i <= 1'b1;
      rw(1, 10'h100, 32'h0000_0001);
      rw(0, 10'h090, 0);
      check("held supply", rd, 32'h0000_a008);
      check("low supply", 32'(low_supply_flag_o), 32'h0000_0001);
      check("fault flag", 32'(any_fault_flag_o), 32'h0000_0001);
      @(posedge clk_i);
      supply_pin_low_i <= 1'b0;
      rw(1, 10'h100, 32'h0000_0001);
      rw(0, 10'h090, 0);
      check("cleared error", rd, 32'h0000_a000);
      for (int i = 0; i < 21; i++) begin
         rw(1, 10'h100, 32'h0000_0007);
         fire(i);
         a = EXP[i][12] ? 10'h098 : 10'h090;
         rw(0, a, 0);
         check("flag word", rd, {16'h0000, EXP[i]});
         check("summary", 32'(caution_summary_o), 32'(EXP[i][12] && i != 20));
         rw(1, 10'h100, 32'h0000_0003);
         rw(0, a, 0);
         check("after clear", rd, {16'h0000, EXP[i][15:12], 12'(i == 18 || i == 19)});
      end
      rw(1, 10'h10c, 32'h0000_0fff);
      fire(14);
      rw(0, 10'h098, 0);
      check("masked warning", rd, 32'h0000_b010);
      check("masked summary", 32'(caution_summary_o), 32'h0000_0000);
      check("masked fault", 32'(any_fault_flag_o), 32'h0000_0000);
      rw(1, 10'h10c, 32'h0000_0000);
      rw(1, 10'h100, 32'h0000_0007);
      rw(1, 10'h098, 32'hffff_ffff);
      rw(0, 10'h098, 0);
      check("read-only word", rd, 32'h0000_b000);
      rw(0, 10'h3fc, 0);
      check("unmapped word", rd, 32'h0000_0000);
      // Checksum off, eighth turns, summary masked, supply error masked
      rw(1, 10'h104, 32'h0008_000e);
      fire(9);
      fire(18);
      rw(0, 10'h098, 0);
      check("unchecked packet", rd, 32'h0000_b000);
      fire(14);
      @(posedge clk_i);
      supply_pin_low_i <= 1'b1;
      rw(0, 10'h090, 0);
      check("masked error", rd, 32'h0000_a008);
      check("masked low supply", 32'(low_supply_flag_o), 32'h0000_0000);
      check("summary masked", 32'(caution_summary_o), 32'h0000_0000);
      check("warning fault", 32'(any_fault_flag_o), 32'h0000_0001);
      for (int k = 0; k < 5; k++) begin
         seed = xs(seed);
         traw = (k < 4) ? TV[k] : $signed(16'(seed % 1921)) - 16'sh02a8;
         fire(12);
         rw(0, 10'h0a0, 0);
         check("temperature", rd, exp_temp(traw));
      end
      complete_run();
   end
endmodule

// ===== tb/dfr_host.sv
`timescale 1ns/1ps
// ------------------------------------------
// Host reading the flag words
// ------------------------------------------
module dfr_host (
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [9:0] adr_o,
   output logic [31:0] dat_o,
   output logic [3:0] sel_o
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 10'h000;
      dat_o = 32'h0000_0000;
      sel_o = 4'h0;
   end
   task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] wd,
         output logic [31:0] rd, output logic ok);
      int n;
      ok = 1'b0;
      rd = 32'h0000_0000;
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      dat_o <= wd;
      sel_o <= 4'hf;
      for (n = 0; n < 16 && !ok; n++) begin
         @(posedge clk_i);
         if (ack_i === 1'b1) begin
            ok = 1'b1;
            rd = dat_i;
         end
      end
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      // Stale data not left on the bus
      dat_o <= ~wd;
   endtask
endmodule
